// ### inc/ppc_regs.svh
`ifndef PPC_REGS_SVH
`define PPC_REGS_SVH

// Command codes of the configuration registers.
`define PPC_CMD_PHASE_LIMIT 8'hd7
`define PPC_CMD_HICCUP 8'hd8
`define PPC_CMD_UV_PG 8'hd9
`define PPC_CMD_SLEW 8'hda
`define PPC_CMD_LOW_POWER 8'he5
`define PPC_CMD_FUNC_CTRL 8'hea

// Reset values.
`define PPC_RST_PHASE_LIMIT 8'h14
`define PPC_RST_HICCUP 8'h00
`define PPC_RST_UV_PG 8'h00
`define PPC_RST_SLEW 8'h00
`define PPC_RST_LOW_POWER 8'h00
`define PPC_RST_FUNC_CTRL 16'h0000

// Writable masks; reserved bits read zero or hold the fixed field.
`define PPC_MASK_PHASE_LIMIT 8'h1f
`define PPC_MASK_HICCUP 8'h3f
`define PPC_MASK_UV_PG 8'h0f
`define PPC_MASK_SLEW 8'h0f
`define PPC_MASK_LOW_POWER 8'h03
`define PPC_MASK_FUNC_CTRL 16'h0608

// Field positions.
`define PPC_BIT_LP_BUS 0
`define PPC_BIT_LP_PIN 1
`define PPC_BIT_PHASE_OP 3
`define PPC_BIT_SINK_OFF 9
`define PPC_BIT_ADJ_HICCUP 10

// Over-current cycle count and time steps.
`define PPC_OC_CYCLES 5'd31
`define PPC_CLK_NS 40
`define PPC_HICCUP_STEP_MS 4
`define PPC_HICCUP_STEP_CYC (`PPC_HICCUP_STEP_MS * 1000000 / `PPC_CLK_NS)
`define PPC_SLEW_BASE_NS_PER_MV 10000
`define PPC_SLEW_STEP_NS_PER_MV 2500
`define PPC_SS_HICCUP_FACTOR 5

`endif

// ### inc/ppc_pkg.sv
package ppc_pkg;

   // Protection state of the converter.
   typedef enum logic [1:0]
   {
      PPC_SOFT = 2'b00,
      PPC_RUN = 2'b01,
      PPC_GOOD = 2'b11,
      PPC_HICCUP = 2'b10
   } ppc_state_type;

endpackage : ppc_pkg

// ### rtl/ppc_sync.sv
`timescale 1ns/1ns
`default_nettype none

// Two-flop synchroniser for level inputs from the pins.
module ppc_sync
#(
   parameter int WIDTH = 1
)
(
   // Clock and reset.
   input wire logic clk,
   input wire logic reset_n,
   // Data.
   input wire logic [WIDTH-1:0] async_in,
   output logic [WIDTH-1:0] sync_out
);

   logic [WIDTH-1:0] stage1;

   // The first stage feeds only the second.
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         stage1 <= '0;
         sync_out <= '0;
      end
      else
      begin
         stage1 <= async_in;
         sync_out <= stage1;
      end
   end

endmodule : ppc_sync
`default_nettype wire

// ### rtl/ppc_config.sv
// Contract
// - Check valley limit each cycle; 31 consecutive overs trigger OCP.
// - Limit code is unsigned, 1.5A per step, zero is 0A, reset 10100.
// - Hiccup interval is 4ms per step, code zero gives 4ms.
// - Programmed interval only with adjustable bit set and total OC fault.
// - Otherwise hiccup lasts about five soft-start times.
// - Control bit 10 picks fixed (0) or adjustable (1) interval.
// - Power-good output is low while any fault is present.
// - Undervoltage when feedback below 69/74/79/84 percent of reference.
// - Undervoltage fault gets the same response as over-current.
// - Power-good rises a set delay after feedback reaches threshold.
// - Slew is 10us/mV plus 2.5us/mV per step, not during soft start; the code applies it in soft start too.
// - Bus low-power bit set disables slave phases.
// - With pin control set, low power follows power-save pin low.
// - Master phase always stays active.
// - Sink mode on when control bit 9 is 0, off when 1.
// - Bit 3 picks single (0) or multi (1) phase and ramp scaling.
// - Reserved control fields are read-only; host leaves them alone.
`timescale 1ns/1ns
`default_nettype none
`include "ppc_regs.svh"

module ppc_config
#(
   parameter int HICCUP_STEP_CYC = `PPC_HICCUP_STEP_CYC
)
(
   // Clock and reset.
   input wire logic clk,
   input wire logic reset_n,
   // Command port from the bus engine.
   input wire logic wr_en,
   input wire logic rd_en,
   input wire logic [7:0] cmd_code,
   input wire logic [15:0] wr_data,
   output logic [15:0] rd_data,
   output logic rd_valid,
   // Analog comparator and phase inputs, asynchronous.
   input wire logic phase_over_limit,
   input wire logic switch_cycle,
   input wire logic total_oc,
   input wire logic fb_below_uv,
   input wire logic fb_above_pg,
   input wire logic other_fault,
   input wire logic power_save_pin,
   // Timing from neighbouring blocks.
   input wire logic [19:0] soft_start_cyc,
   input wire logic [19:0] pg_delay_cyc,
   input wire logic soft_start_done,
   // Controls to the power stage.
   output logic [4:0] phase_current_limit_code,
   output logic [1:0] undervoltage_threshold_sel,
   output logic [1:0] power_good_threshold_sel,
   output logic [16:0] slew_ns_per_mv,
   output logic power_good_out,
   output logic master_phase_on,
   output logic slave_phases_on,
   output logic sink_mode_on,
   output logic multi_phase,
   output logic hiccup_active,
   output ppc_pkg::ppc_state_type prot_state
);

   import ppc_pkg::*;

   logic [7:0] phase_valley_current_limit;
   logic [7:0] hiccup_interval_setting;
   logic [7:0] undervoltage_powergood_threshold;
   logic [7:0] vout_transition_slew;
   logic [7:0] slave_phase_low_power;
   logic [15:0] function_control;
   logic over_q, cyc_q, toc_q, uv_q, pg_q, other_q, ps_q;
   logic cyc_prev;
   logic [4:0] oc_count;
   logic valley_trip;
   logic fault_now;
   logic [25:0] hiccup_cnt;
   logic [25:0] next_hiccup_len;
   logic [19:0] pg_cnt;
   logic adj_hiccup;
   ppc_state_type state;
   // Properties sample on the rising clock and rest during reset.
   default clocking cb @(posedge clk); endclocking
   default disable iff (!reset_n);

   // Pin-side comparators pass a synchroniser before any logic.
   ppc_sync #(.WIDTH(7)) u_sync
   (
      .clk(clk),
      .reset_n(reset_n),
      .async_in({phase_over_limit, switch_cycle, total_oc, fb_below_uv,
                 fb_above_pg, other_fault, power_save_pin}),
      .sync_out({over_q, cyc_q, toc_q, uv_q, pg_q, other_q, ps_q})
   );

   // Register writes; reserved bits are masked so they stay fixed.
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         phase_valley_current_limit <= `PPC_RST_PHASE_LIMIT;
         hiccup_interval_setting <= `PPC_RST_HICCUP;
         undervoltage_powergood_threshold <= `PPC_RST_UV_PG;
         vout_transition_slew <= `PPC_RST_SLEW;
         slave_phase_low_power <= `PPC_RST_LOW_POWER;
         function_control <= `PPC_RST_FUNC_CTRL;
      end
      else if (wr_en)
      begin
         if (cmd_code == `PPC_CMD_PHASE_LIMIT)
         begin
            phase_valley_current_limit <= wr_data[7:0] & `PPC_MASK_PHASE_LIMIT;
         end
         else if (cmd_code == `PPC_CMD_HICCUP)
         begin
            hiccup_interval_setting <= wr_data[7:0] & `PPC_MASK_HICCUP;
         end
         else if (cmd_code == `PPC_CMD_UV_PG)
         begin
            undervoltage_powergood_threshold <= wr_data[7:0] & `PPC_MASK_UV_PG;
         end
         else if (cmd_code == `PPC_CMD_SLEW)
         begin
            vout_transition_slew <= wr_data[7:0] & `PPC_MASK_SLEW;
         end
         else if (cmd_code == `PPC_CMD_LOW_POWER)
         begin
            slave_phase_low_power <= wr_data[7:0] & `PPC_MASK_LOW_POWER;
         end
         else if (cmd_code == `PPC_CMD_FUNC_CTRL)
         begin
            function_control <= wr_data & `PPC_MASK_FUNC_CTRL;
         end
      end
   end

   // Read answer one cycle after the request; unmapped codes read zero.
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         rd_data <= 16'h0000;
         rd_valid <= 1'b0;
      end
      else
      begin
         rd_valid <= rd_en;
         if (!rd_en)
         begin
            rd_data <= rd_data;
         end
         else if (cmd_code == `PPC_CMD_PHASE_LIMIT)
         begin
            rd_data <= {8'h00, phase_valley_current_limit};
         end
         else if (cmd_code == `PPC_CMD_HICCUP)
         begin
            rd_data <= {8'h00, hiccup_interval_setting};
         end
         else if (cmd_code == `PPC_CMD_UV_PG)
         begin
            rd_data <= {8'h00, undervoltage_powergood_threshold};
         end
         else if (cmd_code == `PPC_CMD_SLEW)
         begin
            rd_data <= {8'h00, vout_transition_slew};
         end
         else if (cmd_code == `PPC_CMD_LOW_POWER)
         begin
            rd_data <= {8'h00, slave_phase_low_power};
         end
         else if (cmd_code == `PPC_CMD_FUNC_CTRL)
         begin
            rd_data <= function_control;
         end
         else
         begin
            rd_data <= 16'h0000;
         end
      end
   end

   // Counts consecutive switching cycles that end over the valley limit.
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         cyc_prev <= 1'b0;
         oc_count <= 5'd0;
      end
      else
      begin
         cyc_prev <= cyc_q;
         if (state == PPC_HICCUP)
         begin
            oc_count <= 5'd0;
         end
         else if (cyc_q && !cyc_prev)
         begin
            if (!over_q)
            begin
               oc_count <= 5'd0;
            end
            else if (oc_count != `PPC_OC_CYCLES)
            begin
               oc_count <= oc_count + 5'd1;
            end
         end
      end
   end

   assign valley_trip = (oc_count == `PPC_OC_CYCLES);
   // Undervoltage trips hiccup like over-current but gets the soft-start based interval unless total OC and the adjustable bit pick the programmed one.
   assign fault_now = valley_trip || toc_q || uv_q;
   assign adj_hiccup = function_control[`PPC_BIT_ADJ_HICCUP];

   // Hiccup length picks the programmed or soft-start based interval.
   always_comb
   begin
      if (adj_hiccup && toc_q && !valley_trip)
      begin
         next_hiccup_len = 26'((32'(hiccup_interval_setting[5:0]) + 32'd1)
                               * HICCUP_STEP_CYC);
      end
      else
      begin
         next_hiccup_len = 26'(32'(soft_start_cyc)
                               * `PPC_SS_HICCUP_FACTOR);
      end
   end

   // Protection state: soft start, power good delay, good, hiccup.
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         state <= PPC_SOFT;
         hiccup_cnt <= 26'd0;
         pg_cnt <= 20'd0;
      end
      else
      begin
         case (state)
            PPC_SOFT:
            begin
               pg_cnt <= 20'd0;
               if (fault_now)
               begin
                  state <= PPC_HICCUP;
                  hiccup_cnt <= next_hiccup_len;
               end
               else if (pg_q)
               begin
                  state <= PPC_RUN;
               end
            end
            PPC_RUN:
            begin
               if (fault_now)
               begin
                  state <= PPC_HICCUP;
                  hiccup_cnt <= next_hiccup_len;
               end
               else if (pg_cnt >= pg_delay_cyc)
               begin
                  state <= PPC_GOOD;
               end
               else
               begin
                  pg_cnt <= pg_cnt + 20'd1;
               end
            end
            PPC_GOOD:
            begin
               if (fault_now)
               begin
                  state <= PPC_HICCUP;
                  hiccup_cnt <= next_hiccup_len;
               end
            end
            default:
            begin
               if (hiccup_cnt == 26'd0)
               begin
                  state <= PPC_SOFT;
               end
               else
               begin
                  hiccup_cnt <= hiccup_cnt - 26'd1;
               end
            end
         endcase
      end
   end

   // Control outputs follow the registers on the next edge.
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         phase_current_limit_code <= 5'(`PPC_RST_PHASE_LIMIT);
         undervoltage_threshold_sel <= 2'h0;
         power_good_threshold_sel <= 2'h0;
         slew_ns_per_mv <= 17'(`PPC_SLEW_BASE_NS_PER_MV);
         sink_mode_on <= 1'b1;
         multi_phase <= 1'b0;
         master_phase_on <= 1'b1;
         slave_phases_on <= 1'b1;
      end
      else
      begin
         phase_current_limit_code <=
            phase_valley_current_limit[4:0];
         undervoltage_threshold_sel <=
            undervoltage_powergood_threshold[3:2];
         power_good_threshold_sel <= undervoltage_powergood_threshold[1:0];
         slew_ns_per_mv <= 17'(`PPC_SLEW_BASE_NS_PER_MV
            + 32'(vout_transition_slew[3:0])
            * `PPC_SLEW_STEP_NS_PER_MV);
         sink_mode_on <= !function_control[`PPC_BIT_SINK_OFF];
         multi_phase <= function_control[`PPC_BIT_PHASE_OP];
         master_phase_on <= 1'b1;
         slave_phases_on <=
            !(slave_phase_low_power[`PPC_BIT_LP_BUS]
            || (slave_phase_low_power[`PPC_BIT_LP_PIN] && !ps_q));
      end
   end

   // Status outputs; power-good is low through any fault.
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         power_good_out <= 1'b0;
         hiccup_active <= 1'b0;
         prot_state <= PPC_SOFT;
      end
      else
      begin
         power_good_out <= (state == PPC_GOOD) && !fault_now
                           && !other_q;
         hiccup_active <= (state == PPC_HICCUP);
         prot_state <= state;
      end
   end

   // Assertions.
   chk_valley_trip_hiccup: assert property (
      valley_trip && state != PPC_HICCUP |=> state == PPC_HICCUP)
      else $error("Valley trip did not start hiccup.");
   chk_pg_low_fault: assert property (
      (fault_now || other_q) |=> !power_good_out)
      else $error("Power good high during fault.");
   chk_uv_same_oc: assert property (
      uv_q && state == PPC_GOOD |=> state == PPC_HICCUP)
      else $error("Undervoltage did not start hiccup.");
   chk_master_on: assert property (master_phase_on)
      else $error("Master phase turned off.");
   chk_bus_lp: assert property (
      slave_phase_low_power[0] |=> !slave_phases_on)
      else $error("Bus low power ignored.");
   chk_pin_lp: assert property (
      !slave_phase_low_power[0] && !slave_phase_low_power[1]
      |=> slave_phases_on)
      else $error("Pin acted while pin control off.");
   chk_sink_mode: assert property (
      1'b1 |=> sink_mode_on == !$past(function_control[9]))
      else $error("Sink mode polarity wrong.");
   chk_reserved_ro: assert property (
      rd_valid && $past(cmd_code) == `PPC_CMD_FUNC_CTRL
      |-> (rd_data & ~`PPC_MASK_FUNC_CTRL) == 16'h0000)
      else $error("Reserved control bits read back set.");
   chk_limit_follow: assert property (
      1'b1 |=> phase_current_limit_code
      == $past(phase_valley_current_limit[4:0]))
      else $error("Limit code does not follow its field.");

endmodule : ppc_config
`default_nettype wire

// ### dv/ppc_host_model.sv
`timescale 1ns/1ns
`default_nettype none

// Bus host model that issues one register command at a time.
module ppc_host_model
(
   // Clock.
   input wire logic clk,
   // Command port.
   output logic wr_en,
   output logic rd_en,
   output logic [7:0] cmd_code,
   output logic [15:0] wr_data,
   input wire logic [15:0] rd_data,
   input wire logic rd_valid
);

   // Idle levels at time zero.
   initial
   begin
      wr_en = 1'b0;
      rd_en = 1'b0;
      cmd_code = 8'h00;
      wr_data = 16'h0000;
   end

   // Writes one register; the strobe stands for exactly one edge.
   task automatic write_reg(input logic [7:0] cmd, input logic [15:0] data);
      @(posedge clk);
      wr_en <= 1'b1;
      cmd_code <= cmd;
      wr_data <= data;
      @(posedge clk);
      wr_en <= 1'b0;
      wr_data <= ~data; // Released data must not look valid.
   endtask : write_reg

   // Reads one register and waits a bounded time for the answer.
   task automatic read_reg(input logic [7:0] cmd, output logic [15:0] data);
      int n;
      @(posedge clk);
      rd_en <= 1'b1;
      cmd_code <= cmd;
      @(posedge clk);
      rd_en <= 1'b0;
      #1;
      n = 0;
      while (rd_valid !== 1'b1 && n < 8)
      begin
         @(posedge clk);
         #1;
         n++;
      end
      data = (rd_valid === 1'b1) ? rd_data : 16'hxxxx;
   endtask : read_reg

endmodule : ppc_host_model
`default_nettype wire

// ### dv/ppc_config_tb.sv
`timescale 1ns/1ns
`default_nettype none
`include "ppc_regs.svh"

`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin \
   fail_count++; $display("unexpected %s exp %0h got %0h", nm, e, g); end end

module ppc_config_tb;
   import ppc_pkg::*;

   logic clk, reset_n, wr_en, rd_en, rd_valid, over, swc, tot_oc, uv;
   logic pg_fb, flt, ps_pin, pg, mst, slv, sink, multi, hic;
   logic [7:0] cmd;
   logic [15:0] wdat, rdat, rv;
   logic [4:0] lim;
   logic [1:0] uvs, pgs;
   logic [16:0] slew;
   logic [19:0] ss_cyc, pgd_cyc;
   ppc_state_type st;
   int fail_count = 0;
   int total_checks = 0;
   int n;
   // Register rows: command, value written, value read back.
   logic [7:0] r_cmd [8] = '{8'hd7, 8'hd8, 8'hd9, 8'hda, 8'he5, 8'hea,
      8'hd7, 8'h55};
   logic [15:0] r_wr [8] = '{16'h00ff, 16'h00ff, 16'h00ff, 16'h00ff,
      16'h00ff, 16'h0608, 16'h0000, 16'h00ff};
   logic [15:0] r_rd [8] = '{16'h001f, 16'h003f, 16'h000f, 16'h000f,
      16'h0003, 16'h0608, 16'h0000, 16'h0000};
   // Hiccup rows: control word, source (0 valley, 1 total, 2 under), cycles.
   logic [15:0] h_ea [4] = '{16'h0400, 16'h0400, 16'h0000, 16'h0400};
   int h_src [4] = '{0, 1, 1, 2};
   int h_len [4] = '{40, 30, 40, 30};
   // Soft-start length handed to the block for each hiccup row.
   logic [19:0] h_ss [4] = '{20'd8, 20'd8, 20'd8, 20'd6};

   ppc_host_model host_u (.clk(clk), .wr_en(wr_en), .rd_en(rd_en),
      .cmd_code(cmd), .wr_data(wdat), .rd_data(rdat), .rd_valid(rd_valid));

   ppc_config #(.HICCUP_STEP_CYC(10)) dut_u (.clk(clk), .reset_n(reset_n),
      .wr_en(wr_en), .rd_en(rd_en), .cmd_code(cmd), .wr_data(wdat),
      .rd_data(rdat), .rd_valid(rd_valid), .phase_over_limit(over),
      .switch_cycle(swc), .total_oc(tot_oc), .fb_below_uv(uv),
      .fb_above_pg(pg_fb), .other_fault(flt), .power_save_pin(ps_pin),
      .soft_start_cyc(ss_cyc), .pg_delay_cyc(pgd_cyc), .soft_start_done(1'b0),
      .phase_current_limit_code(lim), .undervoltage_threshold_sel(uvs),
      .power_good_threshold_sel(pgs), .slew_ns_per_mv(slew),
      .power_good_out(pg), .master_phase_on(mst), .slave_phases_on(slv),
      .sink_mode_on(sink), .multi_phase(multi), .hiccup_active(hic),
      .prot_state(st));

   // Clock at 25 MHz.
   initial
   begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end

   // Ends the run with the verdict.
   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", total_checks, fail_count);
      if (fail_count == 0 && total_checks > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask : tally_and_finish

   // Lets writes reach the outputs and inputs pass the synchroniser.
   task automatic settle();
      repeat (4) @(posedge clk);
      #1;
   endtask : settle

   // Gives k switching cycles with the valley comparator at level ov.
   task automatic cycles(input int k, input logic ov);
      repeat (k)
      begin
         @(posedge clk);
         over <= ov;
         swc <= 1'b1;
         repeat (2) @(posedge clk);
         swc <= 1'b0;
         @(posedge clk);
      end
   endtask : cycles

   // Waits for power-good, counting cycles from the feedback rising.
   task automatic wait_good(output int k);
      @(posedge clk);
      pg_fb <= 1'b1;
      k = 0;
      while (pg !== 1'b1 && k < 200)
      begin
         @(posedge clk);
         #1;
         k++;
      end
   endtask : wait_good

   // Watchdog for a hang.
   initial
   begin
      #(40 * 20000);
      fail_count++;
      tally_and_finish();
   end

   initial
   begin
      {reset_n, over, swc, tot_oc, uv, pg_fb, flt} = 7'h00;
      ps_pin = 1'b1;
      ss_cyc = 20'd8;
      pgd_cyc = 20'd12;
      repeat (5) @(posedge clk);
      reset_n <= 1'b1;
      settle();
      `CHK("limit_rst", 5'h14, lim)
      `CHK("slew_rst", 17'h02710, slew)
      `CHK("sink_rst", 1'b1, sink)
      `CHK("pg_rst", 1'b0, pg)
      host_u.read_reg(`PPC_CMD_PHASE_LIMIT, rv);
      `CHK("read_d7_rst", 16'h0014, rv)
      for (int i = 0; i < 8; i++)
      begin
         host_u.write_reg(r_cmd[i], r_wr[i]);
         host_u.read_reg(r_cmd[i], rv);
         `CHK("read_back", r_rd[i], rv)
      end
      // All fields at maximum apart from the limit, now zero.
      `CHK("limit_zero", 5'h00, lim)
      `CHK("uv_sel", 2'h3, uvs)
      `CHK("pg_sel", 2'h3, pgs)
      `CHK("slew_max", 17'h0b98c, slew)
      `CHK("sink_off", 1'b0, sink)
      `CHK("multi", 1'b1, multi)
      `CHK("slave_bus", 1'b0, slv)
      `CHK("master", 1'b1, mst)
      host_u.write_reg(`PPC_CMD_FUNC_CTRL, 16'h0000);
      host_u.write_reg(`PPC_CMD_LOW_POWER, 16'h0002);
      host_u.write_reg(`PPC_CMD_PHASE_LIMIT, 16'h0014);
      settle();
      `CHK("sink_on", 1'b1, sink)
      `CHK("single", 1'b0, multi)
      `CHK("slave_pin_hi", 1'b1, slv)
      @(posedge clk);
      ps_pin <= 1'b0;
      settle();
      `CHK("slave_pin_lo", 1'b0, slv)
      `CHK("master_lp", 1'b1, mst)
      host_u.write_reg(`PPC_CMD_LOW_POWER, 16'h0000);
      settle();
      `CHK("slave_pin_off", 1'b1, slv)
      // Power-good timing and pull-down on a fault.
      wait_good(n);
      `CHK("pg_delay_ok", 1'b1, n >= 12 && n <= 20)
      @(posedge clk);
      flt <= 1'b1;
      settle();
      `CHK("pg_fault", 1'b0, pg)
      @(posedge clk);
      flt <= 1'b0;
      // Thirty over-limit cycles then one clean cycle must not trip.
      host_u.write_reg(`PPC_CMD_HICCUP, 16'h0002);
      cycles(30, 1'b1);
      cycles(1, 1'b0);
      cycles(30, 1'b1);
      cycles(1, 1'b0);
      settle();
      `CHK("no_trip_30", 1'b0, hic)
      for (int i = 0; i < 4; i++)
      begin
         host_u.write_reg(`PPC_CMD_FUNC_CTRL, h_ea[i]);
         ss_cyc <= h_ss[i];
         wait_good(n);
         `CHK("pg_before", 1'b1, pg)
         if (h_src[i] == 0)
            cycles(31, 1'b1);
         @(posedge clk);
         tot_oc <= (h_src[i] == 1);
         uv <= (h_src[i] == 2);
         n = 0;
         while (hic !== 1'b1 && n < 20)
         begin
            @(posedge clk);
            #1;
            n++;
         end
         `CHK("hiccup_on", 1'b1, hic)
         `CHK("pg_hiccup", 1'b0, pg)
         `CHK("state_hic", PPC_HICCUP, st)
         @(posedge clk);
         {over, tot_oc, uv, pg_fb} <= 4'h0;
         n = 0;
         while (hic === 1'b1 && n < 500)
         begin
            @(posedge clk);
            #1;
            n++;
         end
         n = n - h_len[i];
         `CHK("hic_len", 1'b1, n * n <= 9)
      end
      // Reset in mid-run restores the defaults.
      @(posedge clk);
      reset_n <= 1'b0;
      repeat (2) @(posedge clk);
      reset_n <= 1'b1;
      host_u.read_reg(`PPC_CMD_PHASE_LIMIT, rv);
      `CHK("read_d7_rerst", 16'h0014, rv)
      `CHK("state_rerst", PPC_SOFT, st)
      tally_and_finish();
   end

endmodule : ppc_config_tb
`default_nettype wire
